// >>> verilog/sipt_top.sv
// Serial interface, interrupt pin and tilt threshold configuration bank.
`timescale 1ns/10ps
`default_nettype none
`include "sipt_params.svh"

// Operation
// - Reserved low control bits read as zero.
// - Slew automatic unless manual bit set.
// - Bit two sets slew when manual.
// - Swap bit exchanges request-to-pin routing.
// - Three-wire bit makes serial out bidirectional.
// - Status write clears all when per-source off.
// - Status write clears masked bits when per-source.
// - Pin A polarity from config bit two.
// - Pin A open-drain or push-pull, bit three.
// - Pin B polarity, or GPIO level, bit six.
// - Pin B open-drain or push-pull, bit seven.
// - Fifteen-bit threshold split over two registers.
// - Sample above threshold reports tilt.
// - Below threshold reports flat or flip.
// - Tilt-35 detection sets status bit four.
module sipt_top
    import sipt_pkg::*;
(
    input wire logic CORE_CLK_I,         // Core clock, 20 MHz.
    input wire logic SRST_I,             // Synchronous reset, active high.
    input wire logic LINK_CLK_I,         // Serial link clock from the host.
    input wire logic CS_N_I,             // Serial frame select, active low.
    input wire logic SDI_I,              // Serial data in pin.
    input wire logic SDO_I,              // Serial out pin, input side.
    output logic SDO_O,                  // Serial out pin, output side.
    output logic SDO_OE_O,               // Serial out pin driven.
    input wire logic AUTO_SLEW_I,        // Slew choice of the automatic control.
    output logic SLEW_EN_O,              // Pad slew-rate control enabled.
    input wire logic REQ_B_I,            // Request B from other event logic.
    input wire logic GPIO_MODE_B_I,      // Pin B used as general output.
    output logic IRQ_A_O,                // Interrupt pin A level.
    output logic IRQ_A_OE_O,             // Interrupt pin A driven.
    output logic IRQ_B_O,                // Interrupt pin B level.
    output logic IRQ_B_OE_O,             // Interrupt pin B driven.
    input wire logic SAMPLE_VALID_I,     // New sample strobe.
    input wire logic [14:0] SAMPLE_I,    // Tilt/flip sample magnitude.
    input wire logic [14:0] TILT35_I,    // Tilt-35 sample magnitude.
    input wire logic Z_NEG_I,            // Z-axis value negative.
    input wire logic Z_ORIENT_I,         // Z orientation setting.
    output sipt_orient_t ORIENT_O,       // Last orientation result.
    output logic [7:0] INT_STATUS_O,     // Pending interrupt flags.
    output logic [14:0] THRESHOLD_O      // Shared tilt threshold.
);

    logic l_wr_tgl, l_rd_tgl;
    logic [6:0] l_wr_addr, l_rd_addr;
    logic [7:0] l_wr_data;
    logic [2:0] wr_sy_r, rd_sy_r;
    logic wr_ev, rd_ev;
    logic [7:0] ictl_r, ictl_nxt;
    logic [7:0] pcfg_r, pcfg_nxt;
    logic [7:0] thr_lo_r, thr_lo_nxt;
    logic [6:0] thr_hi_r, thr_hi_nxt;
    logic [7:0] stat_r, stat_nxt;
    logic [7:0] rd_data_r, rd_data_nxt;
    logic rd_ack_r, rd_ack_nxt;
    logic [7:0] stat_set, stat_kept;
    logic [14:0] thr_val;
    sipt_orient_t cmp_orient;
    logic cmp_t35;
    sipt_orient_t orient_r, orient_nxt;
    logic req_a, route_a, route_b;
    logic slew_nxt, slew_r;
    logic ia_r, ia_nxt, ia_oe_r, ia_oe_nxt;
    logic ib_r, ib_nxt, ib_oe_r, ib_oe_nxt;

    // Link side logic on the host's clock.
    sipt_spi_link u_link (
        .lclk_i(LINK_CLK_I),
        .srst_i(SRST_I),
        .cs_n_i(CS_N_I),
        .sdi_i(SDI_I),
        .sdo_in_i(SDO_I),
        .three_wire_i(ictl_r[`SIPT_IC_THREE_WIRE]),
        .rd_data_i(rd_data_r),
        .rd_ack_tgl_i(rd_ack_r),
        .sdo_o(SDO_O),
        .sdo_oe_o(SDO_OE_O),
        .wr_tgl_o(l_wr_tgl),
        .wr_addr_o(l_wr_addr),
        .wr_data_o(l_wr_data),
        .rd_tgl_o(l_rd_tgl),
        .rd_addr_o(l_rd_addr)
    );

    // Tilt/flip and tilt-35 compare against the shared threshold.
    sipt_tilt_cmp u_cmp (
        .sample_i(SAMPLE_I),
        .tilt35_i(TILT35_I),
        .thr_i(thr_val),
        .z_neg_i(Z_NEG_I),
        .z_orient_i(Z_ORIENT_I),
        .orient_o(cmp_orient),
        .tilt35_hit_o(cmp_t35)
    );

    // Two-stage synchronisers plus a history stage turn toggles into pulses.
    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            wr_sy_r <= 3'h0;
            rd_sy_r <= 3'h0;
        end else begin
            wr_sy_r <= {wr_sy_r[1:0], l_wr_tgl};
            rd_sy_r <= {rd_sy_r[1:0], l_rd_tgl};
        end
    end
    assign wr_ev = wr_sy_r[1] ^ wr_sy_r[2];
    assign rd_ev = rd_sy_r[1] ^ rd_sy_r[2];

    // The threshold is one 15-bit value split over low and high bytes.
    assign thr_val = {thr_hi_r, thr_lo_r};

    // Status events raised by the detectors on each sample.
    always_comb begin
        stat_set = 8'h00;
        if (SAMPLE_VALID_I) begin
            stat_set[`SIPT_ST_TILT] = (cmp_orient == SIPT_OR_TILT);
            stat_set[`SIPT_ST_FLATFLIP] = (cmp_orient == SIPT_OR_FLAT) ||
                                          (cmp_orient == SIPT_OR_FLIP);
            stat_set[`SIPT_ST_TILT35] = cmp_t35;
        end
    end

    // Register writes, status clearing and read answers.
    always_comb begin
        ictl_nxt = ictl_r;
        pcfg_nxt = pcfg_r;
        thr_lo_nxt = thr_lo_r;
        thr_hi_nxt = thr_hi_r;
        stat_kept = stat_r;
        rd_data_nxt = rd_data_r;
        rd_ack_nxt = rd_ack_r;
        orient_nxt = orient_r;
        if (SAMPLE_VALID_I) begin
            orient_nxt = cmp_orient;
        end
        if (wr_ev) begin
            unique case (l_wr_addr)
                `SIPT_ADDR_IFACE_CTRL: ictl_nxt = l_wr_data & `SIPT_IC_RESV_MASK;
                `SIPT_ADDR_PIN_CFG: pcfg_nxt = l_wr_data;
                `SIPT_ADDR_THR_LOW: thr_lo_nxt = l_wr_data;
                `SIPT_ADDR_THR_HIGH: thr_hi_nxt = l_wr_data[6:0];
                `SIPT_ADDR_INT_STATUS: begin
                    if (ictl_r[`SIPT_IC_PER_SRC_CLR]) begin
                        stat_kept = stat_r & ~l_wr_data;
                    end else begin
                        stat_kept = 8'h00;
                    end
                end
                default: begin
                end
            endcase
        end
        // A new event wins over a clear in the same cycle.
        stat_nxt = stat_kept | stat_set;
        if (rd_ev) begin
            rd_ack_nxt = rd_sy_r[1];
            unique case (l_rd_addr)
                `SIPT_ADDR_IFACE_CTRL: rd_data_nxt = ictl_r;
                `SIPT_ADDR_INT_STATUS: rd_data_nxt = stat_r;
                default: rd_data_nxt = `SIPT_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            ictl_r <= `SIPT_RST_BYTE;
            pcfg_r <= `SIPT_RST_BYTE;
            thr_lo_r <= `SIPT_RST_BYTE;
            thr_hi_r <= `SIPT_RST_THR_HIGH;
            stat_r <= `SIPT_RST_BYTE;
            rd_data_r <= `SIPT_RST_BYTE;
            rd_ack_r <= 1'b0;
            orient_r <= SIPT_OR_NONE;
        end else begin
            ictl_r <= ictl_nxt;
            pcfg_r <= pcfg_nxt;
            thr_lo_r <= thr_lo_nxt;
            thr_hi_r <= thr_hi_nxt;
            stat_r <= stat_nxt;
            rd_data_r <= rd_data_nxt;
            rd_ack_r <= rd_ack_nxt;
            orient_r <= orient_nxt;
        end
    end

    // Request A is any pending flag; the swap bit exchanges the two pins.
    assign req_a = |stat_r;
    assign route_a = ictl_r[`SIPT_IC_SWAP] ? REQ_B_I : req_a;
    assign route_b = ictl_r[`SIPT_IC_SWAP] ? req_a : REQ_B_I;

    // Slew choice and interrupt pin drive, registered onto the pins.
    always_comb begin
        slew_nxt = ictl_r[`SIPT_IC_SLEW_MAN] ? ictl_r[`SIPT_IC_SLEW_EN] :
                   AUTO_SLEW_I;
        // Active level follows the polarity bit, idle level is its inverse.
        ia_nxt = route_a ? pcfg_r[`SIPT_PC_A_HIGH] : ~pcfg_r[`SIPT_PC_A_HIGH];
        ia_oe_nxt = pcfg_r[`SIPT_PC_A_PP] | route_a;
        if (GPIO_MODE_B_I) begin
            ib_nxt = pcfg_r[`SIPT_PC_B_HIGH];
            ib_oe_nxt = pcfg_r[`SIPT_PC_B_PP] | ~pcfg_r[`SIPT_PC_B_HIGH];
        end else begin
            ib_nxt = route_b ? pcfg_r[`SIPT_PC_B_HIGH] : ~pcfg_r[`SIPT_PC_B_HIGH];
            ib_oe_nxt = pcfg_r[`SIPT_PC_B_PP] | route_b;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SRST_I) begin
            slew_r <= 1'b0;
            ia_r <= 1'b1;
            ia_oe_r <= 1'b0;
            ib_r <= 1'b1;
            ib_oe_r <= 1'b0;
        end else begin
            slew_r <= slew_nxt;
            ia_r <= ia_nxt;
            ia_oe_r <= ia_oe_nxt;
            ib_r <= ib_nxt;
            ib_oe_r <= ib_oe_nxt;
        end
    end

    assign SLEW_EN_O = slew_r;
    assign IRQ_A_O = ia_r;
    assign IRQ_A_OE_O = ia_oe_r;
    assign IRQ_B_O = ib_r;
    assign IRQ_B_OE_O = ib_oe_r;
    assign ORIENT_O = orient_r;
    assign INT_STATUS_O = stat_r;
    assign THRESHOLD_O = thr_val;

    // Checks on the core clock.
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (SRST_I);

    sequence ctl_write_s;
        wr_ev && (l_wr_addr == `SIPT_ADDR_IFACE_CTRL);
    endsequence

    sequence stat_write_s;
        wr_ev && (l_wr_addr == `SIPT_ADDR_INT_STATUS) && !stat_set[0] && !stat_set[1]
            && !stat_set[4];
    endsequence

    resv_low_zero_a: assert property (ctl_write_s |=> ictl_r[1:0] == 2'b00)
        else $error("reserved control bits not zero");
    slew_auto_a: assert property (!ictl_r[3] |=> SLEW_EN_O == $past(AUTO_SLEW_I))
        else $error("slew not following automatic control");
    slew_manual_a: assert property (ictl_r[3] |=> SLEW_EN_O == $past(ictl_r[2]))
        else $error("manual slew bit ignored");
    swap_route_a: assert property (ictl_r[4] && req_a && !pcfg_r[7] |=>
        IRQ_B_OE_O || $past(GPIO_MODE_B_I))
        else $error("swapped request A not on pin B");
    clear_all_a: assert property (stat_write_s and (!ictl_r[6]) |=> stat_r == 8'h00)
        else $error("status not fully cleared");
    clear_mask_a: assert property (stat_write_s and ictl_r[6] |=>
        stat_r == ($past(stat_r) & ~$past(l_wr_data)))
        else $error("masked clear wrong");
    pin_a_level_a: assert property (!ictl_r[4] && req_a |=>
        IRQ_A_O == $past(pcfg_r[2]))
        else $error("pin A active level wrong");
    pin_a_od_a: assert property (!pcfg_r[3] && !route_a |=> !IRQ_A_OE_O)
        else $error("open-drain pin A driven while idle");
    pin_b_gpio_a: assert property (GPIO_MODE_B_I |=> IRQ_B_O == $past(pcfg_r[6]))
        else $error("pin B output level wrong");
    pin_b_pp_a: assert property (pcfg_r[7] |=> IRQ_B_OE_O)
        else $error("push-pull pin B not driven");
    tilt35_set_a: assert property (SAMPLE_VALID_I && cmp_t35 |=> stat_r[4] [*1])
        else $error("tilt-35 flag not set");
    thr_split_a: assert property (wr_ev && l_wr_addr == `SIPT_ADDR_THR_HIGH |=>
        THRESHOLD_O[14:8] == $past(l_wr_data[6:0]))
        else $error("threshold high byte wrong");

endmodule
`default_nettype wire

// >>> verilog/sipt_params.svh
// Offsets, field positions, reset values and link framing counts of the config bank.
`ifndef SIPT_PARAMS_SVH
`define SIPT_PARAMS_SVH

// Register addresses as seen on the serial link.
`define SIPT_ADDR_INT_STATUS 7'h14
`define SIPT_ADDR_IFACE_CTRL 7'h31
`define SIPT_ADDR_PIN_CFG 7'h33
`define SIPT_ADDR_THR_LOW 7'h40
`define SIPT_ADDR_THR_HIGH 7'h41

// Reset values.
`define SIPT_RST_BYTE 8'h00
`define SIPT_RST_THR_HIGH 7'h00

// Interface control fields.
`define SIPT_IC_SLEW_EN 2
`define SIPT_IC_SLEW_MAN 3
`define SIPT_IC_SWAP 4
`define SIPT_IC_THREE_WIRE 5
`define SIPT_IC_PER_SRC_CLR 6
`define SIPT_IC_RESV_MASK 8'hFC

// Interrupt pin configuration fields.
`define SIPT_PC_A_HIGH 2
`define SIPT_PC_A_PP 3
`define SIPT_PC_B_HIGH 6
`define SIPT_PC_B_PP 7

// Interrupt status fields.
`define SIPT_ST_TILT 0
`define SIPT_ST_FLATFLIP 1
`define SIPT_ST_TILT35 4

// Link framing: bit index of the last bit of a byte and of the read wait gap.
`define SIPT_BYTE_LAST 4'h7
`define SIPT_RD_WAIT_LAST 4'hF

`endif

// >>> verilog/sipt_pkg.sv
// Types shared by the serial config bank modules.
package sipt_pkg;

    // Link frame phases, Gray coded in the order command, write, wait, read.
    typedef enum logic [1:0] {
        SIPT_LS_CMD  = 2'b00,
        SIPT_LS_WR   = 2'b01,
        SIPT_LS_WAIT = 2'b11,
        SIPT_LS_RD   = 2'b10
    } sipt_lstate_t;

    // Orientation reported by the tilt/flip compare.
    typedef enum logic [1:0] {
        SIPT_OR_NONE = 2'b00,
        SIPT_OR_TILT = 2'b01,
        SIPT_OR_FLAT = 2'b10,
        SIPT_OR_FLIP = 2'b11
    } sipt_orient_t;

endpackage

// >>> verilog/sipt_tilt_cmp.sv
// Threshold compare for the tilt/flip and tilt-35 detectors.
`timescale 1ns/10ps
`default_nettype none
`include "sipt_params.svh"

module sipt_tilt_cmp
    import sipt_pkg::*;
(
    input wire logic [14:0] sample_i,    // Tilt/flip sample magnitude.
    input wire logic [14:0] tilt35_i,    // Tilt-35 sample magnitude.
    input wire logic [14:0] thr_i,       // Shared threshold.
    input wire logic z_neg_i,            // Z-axis value is negative.
    input wire logic z_orient_i,         // Z orientation setting.
    output sipt_orient_t orient_o,       // Orientation result.
    output logic tilt35_hit_o            // Tilt-35 amount reached.
);

    // Above the threshold is tilt, below it is flat or flip by the Z axis.
    always_comb begin
        if (sample_i > thr_i) begin
            orient_o = SIPT_OR_TILT;
        end else if (sample_i < thr_i) begin
            orient_o = (z_neg_i ^ z_orient_i) ? SIPT_OR_FLIP : SIPT_OR_FLAT;
        end else begin
            orient_o = SIPT_OR_NONE;
        end
    end

    // Tilt-35 fires once the tilt amount passes the same threshold.
    assign tilt35_hit_o = (tilt35_i > thr_i);

endmodule
`default_nettype wire

// >>> verilog/sipt_spi_link.sv
// Serial link slave running on the link clock, crossing to the core by toggles.
`timescale 1ns/10ps
`default_nettype none
`include "sipt_params.svh"

module sipt_spi_link
    import sipt_pkg::*;
(
    input wire logic lclk_i,             // Link clock from the host.
    input wire logic srst_i,             // Core reset, used asynchronously here.
    input wire logic cs_n_i,             // Frame select, active low.
    input wire logic sdi_i,              // Serial data in pin.
    input wire logic sdo_in_i,           // Level seen on the serial out pin.
    input wire logic three_wire_i,       // Three-wire mode level from the core.
    input wire logic [7:0] rd_data_i,    // Read answer from the core.
    input wire logic rd_ack_tgl_i,       // Read answer toggle from the core.
    output logic sdo_o,                  // Serial out pin level.
    output logic sdo_oe_o,               // Serial out pin driven.
    output logic wr_tgl_o,               // Write event toggle.
    output logic [6:0] wr_addr_o,        // Write address, held.
    output logic [7:0] wr_data_o,        // Write data, held.
    output logic rd_tgl_o,               // Read request toggle.
    output logic [6:0] rd_addr_o         // Read address, held.
);

    logic frame_rst;
    sipt_lstate_t st_r, st_nxt;
    logic [3:0] cnt_r, cnt_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic [7:0] out_r, out_nxt;
    logic oe_r, oe_nxt;
    logic wr_tgl_r, wr_tgl_nxt;
    logic rd_tgl_r, rd_tgl_nxt;
    logic [6:0] wr_addr_r, wr_addr_nxt;
    logic [7:0] wr_data_r, wr_data_nxt;
    logic [6:0] rd_addr_r, rd_addr_nxt;
    logic tw_s1_r, tw_s2_r;
    logic ack_s1_r, ack_s2_r;
    logic mosi;

    assign frame_rst = srst_i | cs_n_i;

    // In three-wire mode the host data comes back in on the serial out pin.
    assign mosi = tw_s2_r ? sdo_in_i : sdi_i;

    // Frame sequencing: command byte, then write data or wait gap and read data.
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r + 4'h1;
        sh_nxt = {sh_r[6:0], mosi};
        out_nxt = out_r;
        oe_nxt = oe_r;
        wr_tgl_nxt = wr_tgl_r;
        rd_tgl_nxt = rd_tgl_r;
        wr_addr_nxt = wr_addr_r;
        wr_data_nxt = wr_data_r;
        rd_addr_nxt = rd_addr_r;
        unique case (st_r)
            SIPT_LS_CMD: begin
                if (cnt_r == `SIPT_BYTE_LAST) begin
                    cnt_nxt = 4'h0;
                    if (sh_nxt[7]) begin
                        st_nxt = SIPT_LS_WAIT;
                        rd_addr_nxt = sh_nxt[6:0];
                        rd_tgl_nxt = ~rd_tgl_r;
                    end else begin
                        st_nxt = SIPT_LS_WR;
                        wr_addr_nxt = sh_nxt[6:0];
                    end
                end
            end
            SIPT_LS_WR: begin
                if (cnt_r == `SIPT_BYTE_LAST) begin
                    cnt_nxt = 4'h0;
                    st_nxt = SIPT_LS_CMD;
                    wr_data_nxt = sh_nxt;
                    wr_tgl_nxt = ~wr_tgl_r;
                end
            end
            SIPT_LS_WAIT: begin
                if (cnt_r == `SIPT_RD_WAIT_LAST) begin
                    cnt_nxt = 4'h0;
                    st_nxt = SIPT_LS_RD;
                    out_nxt = (ack_s2_r == rd_tgl_r) ? rd_data_i : `SIPT_RST_BYTE;
                    oe_nxt = 1'b1;
                end
            end
            SIPT_LS_RD: begin
                out_nxt = {out_r[6:0], 1'b0};
                if (cnt_r == `SIPT_BYTE_LAST) begin
                    cnt_nxt = 4'h0;
                    st_nxt = SIPT_LS_CMD;
                    oe_nxt = 1'b0;
                end
            end
        endcase
    end

    // Frame state clears whenever select is released.
    always_ff @(posedge lclk_i or posedge frame_rst) begin
        if (frame_rst) begin
            st_r <= SIPT_LS_CMD;
            cnt_r <= 4'h0;
            sh_r <= `SIPT_RST_BYTE;
            out_r <= `SIPT_RST_BYTE;
            oe_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            sh_r <= sh_nxt;
            out_r <= out_nxt;
            oe_r <= oe_nxt;
        end
    end

    // Toggles, held words and synchronisers persist across frames.
    always_ff @(posedge lclk_i or posedge srst_i) begin
        if (srst_i) begin
            wr_tgl_r <= 1'b0;
            rd_tgl_r <= 1'b0;
            wr_addr_r <= 7'h00;
            wr_data_r <= `SIPT_RST_BYTE;
            rd_addr_r <= 7'h00;
            tw_s1_r <= 1'b0;
            tw_s2_r <= 1'b0;
            ack_s1_r <= 1'b0;
            ack_s2_r <= 1'b0;
        end else begin
            wr_tgl_r <= wr_tgl_nxt;
            rd_tgl_r <= rd_tgl_nxt;
            wr_addr_r <= wr_addr_nxt;
            wr_data_r <= wr_data_nxt;
            rd_addr_r <= rd_addr_nxt;
            tw_s1_r <= three_wire_i;
            tw_s2_r <= tw_s1_r;
            ack_s1_r <= rd_ack_tgl_i;
            ack_s2_r <= ack_s1_r;
        end
    end

    assign sdo_o = out_r[7];
    assign sdo_oe_o = oe_r;
    assign wr_tgl_o = wr_tgl_r;
    assign wr_addr_o = wr_addr_r;
    assign wr_data_o = wr_data_r;
    assign rd_tgl_o = rd_tgl_r;
    assign rd_addr_o = rd_addr_r;

endmodule
`default_nettype wire

// >>> verilog/unused_placeholder_none.sv
// Empty unit kept intentionally minimal.
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// >>> verification/sipt_host_model.sv
// Host model of the serial link that frames writes and reads and resolves the serial out wire.
`timescale 1ns/10ps
`default_nettype none

module sipt_host_model (
    input wire logic three_wire_i,  // Host data goes on the serial out wire.
    input wire logic tie_i,         // Data in wire tied to the serial out wire.
    input wire logic sdo_i,         // Device serial out level.
    input wire logic sdo_oe_i,      // Device drives serial out.
    output logic lclk_o,            // Link clock, still between frames.
    output logic cs_n_o,            // Frame select, active low.
    output logic sdi_o,             // Serial data in wire.
    output logic sdo_line_o,        // Resolved serial out wire.
    output logic rd_tgl_o,          // Toggles when a read byte is in.
    output logic [7:0] rd_byte_o    // Last byte read.
);
    logic drv_r;
    logic bit_r;
    logic last_r;

    // A released wire shows the inverse of its last level, so stale data never passes.
    assign sdo_line_o = sdo_oe_i ? sdo_i : (drv_r ? bit_r : ~last_r);
    // In three-wire mode the data in wire carries junk, unless the two wires are tied.
    assign sdi_o = tie_i ? sdo_line_o : (three_wire_i ? ~bit_r : bit_r);

    // Remembers the last driven level of the serial out wire.
    always @(posedge lclk_o) begin
        if (sdo_oe_i || drv_r) begin
            last_r <= sdo_line_o;
        end
    end

    // Idle levels at time zero.
    initial begin
        lclk_o = 1'b0;
        cs_n_o = 1'b1;
        drv_r = 1'b0;
        bit_r = 1'b0;
        last_r = 1'b0;
        rd_tgl_o = 1'b0;
        rd_byte_o = 8'h00;
    end

    // One frame: command, then a data byte, or the wait gap and a read byte.
    task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, output logic [7:0] got);
        got = 8'h00;
        #7;
        cs_n_o = 1'b0;
        drv_r = three_wire_i;
        for (int i = 0; i < (cmd[7] ? 32 : 16); i++) begin
            if (cmd[7] && i == 8) begin
                drv_r = 1'b0;
            end
            if (i < 16) begin
                bit_r = (i < 8) ? cmd[7 - i] : wd[15 - i];
            end
            #16;
            if (i >= 24) begin
                got = {got[6:0], sdo_line_o};
            end
            lclk_o = 1'b1;
            #16;
            lclk_o = 1'b0;
        end
        #16;
        drv_r = 1'b0;
        cs_n_o = 1'b1;
        #400;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] junk;
        xfer({1'b0, a}, d, junk);
    endtask

    task automatic rd(input logic [6:0] a);
        logic [7:0] b;
        xfer({1'b1, a}, 8'h00, b);
        rd_byte_o = b;
        rd_tgl_o = ~rd_tgl_o;
    endtask
endmodule
`default_nettype wire

// >>> verification/tb_sipt_top.sv
// Self-checking bench of the serial config bank driven through the host model.
`timescale 1ns/10ps
`default_nettype none
`include "sipt_params.svh"

module tb_sipt_top;
    import sipt_pkg::*;
    logic clk, srst, aslew, req_b, gpio_b, sv, zn, zo, tw, sdo, sdo_oe, lclk, cs_n, sdi, line;
    logic slew, ia, ia_oe, ib, ib_oe, rtg, tie;
    logic [14:0] samp, t35, thr, thr_o;
    logic [7:0] st, cfg, rbyte, junk;
    sipt_orient_t ori;
    logic [7:0] exp_q[$];
    logic [31:0] seed;
    int err_total, samples_checked;

    sipt_top dut_u (.CORE_CLK_I(clk), .SRST_I(srst), .LINK_CLK_I(lclk), .CS_N_I(cs_n),
        .SDI_I(sdi), .SDO_I(line), .SDO_O(sdo), .SDO_OE_O(sdo_oe), .AUTO_SLEW_I(aslew),
        .SLEW_EN_O(slew), .REQ_B_I(req_b), .GPIO_MODE_B_I(gpio_b), .IRQ_A_O(ia),
        .IRQ_A_OE_O(ia_oe), .IRQ_B_O(ib), .IRQ_B_OE_O(ib_oe), .SAMPLE_VALID_I(sv),
        .SAMPLE_I(samp), .TILT35_I(t35), .Z_NEG_I(zn), .Z_ORIENT_I(zo), .ORIENT_O(ori),
        .INT_STATUS_O(st), .THRESHOLD_O(thr_o));
    sipt_host_model host_u (.three_wire_i(tw), .tie_i(tie), .sdo_i(sdo), .sdo_oe_i(sdo_oe),
        .lclk_o(lclk), .cs_n_o(cs_n), .sdi_o(sdi), .sdo_line_o(line), .rd_tgl_o(rtg),
        .rd_byte_o(rbyte));

    task automatic step();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] want);
        samples_checked++;
        if (seen !== want) begin
            err_total++;
            $display("wrong value at %0t ns: seen %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic chk1(input logic seen, input logic want);
        chk({15'h0000, seen}, {15'h0000, want});
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic rd_exp(input logic [6:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.rd(a);
    endtask

    // A harmless frame to an unmapped place lets a mode change settle on the link.
    task automatic flush();
        host_u.xfer(8'h20, 8'h00, junk);
    endtask

    task automatic strobe(input logic [14:0] s, input logic [14:0] t);
        step();
        @(negedge clk);
        samp = s;
        t35 = t;
        zn = seed[0];
        zo = seed[1];
        sv = 1'b1;
        @(negedge clk);
        sv = 1'b0;
        @(negedge clk);
    endtask

    // Pin levels and enables worked out from routing, polarity and drive mode.
    task automatic pins(input logic ra, input logic [7:0] c, input logic sw);
        logic pa;
        logic pb;
        pa = sw ? req_b : ra;
        pb = sw ? ra : req_b;
        chk1(ia_oe, c[3] | pa);
        if (c[3] | pa) chk1(ia, pa ? c[2] : ~c[2]);
        if (gpio_b) begin
            chk({14'h0000, ib_oe, ib}, {14'h0000, c[7] | ~c[6], c[6]});
        end else begin
            chk1(ib_oe, c[7] | pb);
            if (c[7] | pb) chk1(ib, pb ? c[6] : ~c[6]);
        end
    endtask

    // Each read result is compared with the oldest noted expectation.
    always @(rtg) begin
        if ($time > 0) begin
            if (exp_q.size() > 0) chk({8'h00, rbyte}, {8'h00, exp_q.pop_front()});
            else chk(16'h0001, 16'h0000);
        end
    end

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Watchdog that ends a hung run.
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        results();
    end

    // Main sequence.
    initial begin
        {srst, aslew, req_b, gpio_b, sv, zn, zo, tw} = 8'hC0;
        samp = 15'h0000;
        tie = 1'b0;
        t35 = 15'h0000;
        seed = 32'h95a4;
        repeat (5) @(negedge clk);
        srst = 1'b0;
        repeat (3) @(negedge clk);
        chk({1'b0, thr_o}, 16'h0000);
        chk({12'h000, ori, ia_oe, ia}, 16'h0001);
        chk1(slew, 1'b1);
        rd_exp(`SIPT_ADDR_IFACE_CTRL, 8'h00);
        rd_exp(`SIPT_ADDR_PIN_CFG, 8'h00);
        rd_exp(7'h20, 8'h00);
        @(negedge clk);
        aslew = 1'b0;
        host_u.wr(`SIPT_ADDR_IFACE_CTRL, 8'h4F);
        chk1(slew, 1'b1);
        rd_exp(`SIPT_ADDR_IFACE_CTRL, 8'h4C);
        @(negedge clk);
        aslew = 1'b1;
        host_u.wr(`SIPT_ADDR_IFACE_CTRL, 8'h48);
        chk1(slew, 1'b0);
        step();
        thr = {1'b1, seed[13:1], 1'b0};
        host_u.wr(`SIPT_ADDR_THR_LOW, thr[7:0]);
        host_u.wr(`SIPT_ADDR_THR_HIGH, {1'b0, thr[14:8]});
        chk({1'b0, thr_o}, {1'b0, thr});
        strobe(thr + 15'd1, thr + 15'd1);
        chk({14'h0000, ori}, 16'h0001);
        strobe(thr - 15'd1, 15'h0000);
        chk1(ori[1], 1'b1);
        chk({8'h00, st}, 16'h0013);
        rd_exp(`SIPT_ADDR_INT_STATUS, 8'h13);
        host_u.wr(`SIPT_ADDR_INT_STATUS, 8'h01);
        chk({8'h00, st}, 16'h0012);
        host_u.wr(`SIPT_ADDR_INT_STATUS, 8'h12);
        chk({8'h00, st}, 16'h0000);
        host_u.wr(`SIPT_ADDR_IFACE_CTRL, 8'h20);
        flush();
        tw = 1'b1;
        host_u.wr(`SIPT_ADDR_THR_LOW, 8'hA5);
        chk({8'h00, thr_o[7:0]}, 16'h00A5);
        rd_exp(`SIPT_ADDR_IFACE_CTRL, 8'h20);
        host_u.wr(`SIPT_ADDR_IFACE_CTRL, 8'h00);
        tw = 1'b0;
        flush();
        // Tied data wires give three-wire operation with the control bit clear.
        {tie, tw} = 2'b11;
        host_u.wr(`SIPT_ADDR_THR_LOW, 8'h5A);
        chk({8'h00, thr_o[7:0]}, 16'h005A);
        rd_exp(`SIPT_ADDR_IFACE_CTRL, 8'h00);
        {tie, tw} = 2'b00;
        thr = {thr[14:8], 8'h5A};
        for (int k = 0; k < 32; k++) begin
            cfg = {k[3], k[2], 2'b00, k[1], k[0], 2'b00};
            host_u.wr(`SIPT_ADDR_PIN_CFG, cfg);
            host_u.wr(`SIPT_ADDR_IFACE_CTRL, {3'b000, k[4], 4'h0});
            step();
            @(negedge clk);
            req_b = seed[0];
            gpio_b = seed[1];
            strobe(thr + 15'd1, 15'h0000);
            pins(1'b1, cfg, k[4]);
            host_u.wr(`SIPT_ADDR_INT_STATUS, seed[9:2]);
            chk({8'h00, st}, 16'h0000);
            pins(1'b0, cfg, k[4]);
        end
        results();
    end
endmodule
`default_nettype wire
